// >>> hdl/dcr_cfg.svh
`ifndef DCR_CFG_SVH
`define DCR_CFG_SVH
// Byte addresses
`define DCR_OFS_CMP_CTRL 8'h00
`define DCR_OFS_REF_CTRL 8'h04
`define DCR_OFS_IRQ_STAT 8'h08
`define DCR_OFS_IRQ_MASK 8'h0c
// Comparator control fields
`define DCR_B_STOP_IDLE 15
`define DCR_B_B_EVT 13
`define DCR_B_A_EVT 12
`define DCR_B_B_EN 11
`define DCR_B_A_EN 10
`define DCR_B_B_PAD 9
`define DCR_B_A_PAD 8
`define DCR_B_B_RES 7
`define DCR_B_A_RES 6
`define DCR_B_B_INV 5
`define DCR_B_A_INV 4
`define DCR_B_B_NEG 3
`define DCR_B_B_POS 2
`define DCR_B_A_NEG 1
`define DCR_B_A_POS 0
// Writable bits of comparator control
`define DCR_CMP_WMASK 16'h8f3f
// Reference control fields
`define DCR_B_REF_PWR 7
`define DCR_B_REF_PIN 6
`define DCR_B_REF_RANGE 5
`define DCR_B_REF_SRC 4
`define DCR_REF_WMASK 16'h00ff
`define DCR_RST_CMP 16'h0000
`define DCR_RST_REF 16'h0000
`define DCR_RST_MASK 2'h0
`define DCR_RESP_OKAY 2'h0
`define DCR_RESP_SLVERR 2'h2
`endif

// >>> hdl/dcr_pkg.sv
package dcr_pkg;
   typedef enum logic [2:0] {
      DCR_W_IDLE = 3'b001,
      DCR_W_BUSY = 3'b010,
      DCR_W_RESP = 3'b100
   } dcr_wstate_t;
   typedef logic [15:0] dcr_word_t;
endpackage

// >>> hdl/dcr_sync.sv
`timescale 1ns/1ns
`default_nettype none
// Three-stage synchroniser; a change counts once stages two and three agree
module dcr_sync
   import dcr_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Raw and filtered levels
   dcr_sync_if.dst s
);
   logic [1:0] st1;
   logic [1:0] st2;
   logic [1:0] st3;
   logic [1:0] held;
   wire [1:0] agree = ~(st2 ^ st3);
   wire [1:0] next_held = (agree & st3) | (~agree & held);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st1 <= 2'h0;
         st2 <= 2'h0;
         st3 <= 2'h0;
         held <= 2'h0;
      end else begin
         st1 <= s.raw;
         st2 <= st1;
         st3 <= st2;
         held <= next_held;
      end
   end
   assign s.stable = held;
endmodule // dcr_sync
`default_nettype wire

// >>> hdl/dcr_sync_if.sv
`timescale 1ns/1ns
`default_nettype none
interface dcr_sync_if;
   logic [1:0] raw;
   logic [1:0] stable;
   modport src (output raw);
   modport dst (input raw, output stable);
endinterface
`default_nettype wire

// >>> hdl/dcr_top.sv
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`include "dcr_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module dcr_top
   import dcr_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Analog front end: raw comparison results, plus above minus
   input wire logic [1:0] cmp_raw_gt,
   input wire logic device_idle,
   // Comparator A analog steering
   output logic cmp_a_run,
   output logic cmp_a_pos_from_pin,
   output logic cmp_a_neg_from_plus_pin,
   // Comparator B analog steering
   output logic cmp_b_run,
   output logic cmp_b_pos_from_pin,
   output logic cmp_b_neg_from_plus_pin,
   // Result pads
   output logic [1:0] cmp_pad_out,
   output logic [1:0] cmp_pad_oe_n,
   // Reference ladder
   output logic ref_power_on,
   output logic ref_pin_drive,
   output logic ref_range_select,
   output logic ref_source_select,
   output logic [3:0] ref_level_code,
   // Interrupt
   output logic irq
);
   dcr_word_t cmp_ctrl;
   dcr_word_t ref_ctrl;
   logic [1:0] evt;
   logic [1:0] irq_mask;
   logic [1:0] res;
   logic [1:0] res_q;
   logic res_valid;
   dcr_wstate_t wstate;
   logic [7:0] waddr;
   logic [31:0] wdata;
   logic [3:0] wstrb;
   logic aw_got;
   logic w_got;

   dcr_sync_if sif ();
   assign sif.raw = cmp_raw_gt;
   dcr_sync u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .s(sif)
   );

   function automatic dcr_word_t merge16(input dcr_word_t old, input logic [31:0] d,
                                         input logic [3:0] be, input dcr_word_t wm);
      dcr_word_t lane;
      lane = {{8{be[1]}}, {8{be[0]}}} & wm;
      merge16 = (old & ~lane) | (d[15:0] & lane);
   endfunction

   // Enables and inversion
   wire [1:0] en = {cmp_ctrl[`DCR_B_B_EN], cmp_ctrl[`DCR_B_A_EN]};
   wire [1:0] inv = {cmp_ctrl[`DCR_B_B_INV], cmp_ctrl[`DCR_B_A_INV]};
   // Disabled comparator reports zero
   wire [1:0] next_res = en & (sif.stable ^ inv);
   wire [1:0] changed = res_valid ? (next_res ^ res_q) : 2'h0;
   wire idle_block = cmp_ctrl[`DCR_B_STOP_IDLE] & device_idle;
   wire [1:0] pad_en = {cmp_ctrl[`DCR_B_B_PAD], cmp_ctrl[`DCR_B_A_PAD]};

   // Write path decode
   wire aw_hs = s_axi_awvalid & s_axi_awready;
   wire w_hs = s_axi_wvalid & s_axi_wready;
   wire [7:0] next_waddr = aw_hs ? s_axi_awaddr : waddr;
   wire have_aw = aw_got | aw_hs;
   wire have_w = w_got | w_hs;
   wire do_write = (wstate == DCR_W_BUSY) & have_aw & have_w;
   wire [31:0] eff_wdata = w_hs ? s_axi_wdata : wdata;
   wire [3:0] eff_wstrb = w_hs ? s_axi_wstrb : wstrb;
   wire wr_cmp = do_write & (next_waddr == `DCR_OFS_CMP_CTRL);
   wire wr_ref = do_write & (next_waddr == `DCR_OFS_REF_CTRL);
   wire wr_stat = do_write & (next_waddr == `DCR_OFS_IRQ_STAT);
   wire wr_mask = do_write & (next_waddr == `DCR_OFS_IRQ_MASK);
   wire wr_ok = wr_cmp | wr_ref | wr_stat | wr_mask;

   // Read path decode
   wire ar_hs = s_axi_arvalid & s_axi_arready;
   wire rd_cmp = s_axi_araddr == `DCR_OFS_CMP_CTRL;
   wire rd_ref = s_axi_araddr == `DCR_OFS_REF_CTRL;
   wire rd_stat = s_axi_araddr == `DCR_OFS_IRQ_STAT;
   wire rd_mask = s_axi_araddr == `DCR_OFS_IRQ_MASK;
   wire rd_ok = rd_cmp | rd_ref | rd_stat | rd_mask;
   wire [15:0] cmp_view = {cmp_ctrl[15], 1'b0, evt[1], evt[0], cmp_ctrl[11:8],
                           res[1], res[0], cmp_ctrl[5:0]};
   wire [31:0] next_rdata = rd_cmp ? {16'h0000, cmp_view} :
                            rd_ref ? {16'h0000, ref_ctrl} :
                            rd_stat ? {30'h00000000, evt} :
                            rd_mask ? {30'h00000000, irq_mask} : 32'h00000000;

   // Event flags: a clear by read or write-one loses to a new change
   wire [1:0] clr_by_read = (ar_hs & (rd_stat | rd_cmp)) ? 2'h3 : 2'h0;
   wire [1:0] clr_by_w1c = wr_cmp ? ({eff_wdata[`DCR_B_B_EVT], eff_wdata[`DCR_B_A_EVT]} &
                                     {eff_wstrb[1], eff_wstrb[1]}) : 2'h0;
   wire [1:0] next_evt = changed | (evt & ~(clr_by_read | clr_by_w1c));
   wire next_irq = |(evt & irq_mask) & ~idle_block;

   wire dcr_word_t next_cmp = wr_cmp ? merge16(cmp_ctrl, eff_wdata, eff_wstrb,
                                             `DCR_CMP_WMASK) : cmp_ctrl;
   wire dcr_word_t next_ref = wr_ref ? merge16(ref_ctrl, eff_wdata, eff_wstrb,
                                             `DCR_REF_WMASK) : ref_ctrl;
   wire [1:0] next_mask = (wr_mask & eff_wstrb[0]) ? eff_wdata[1:0] : irq_mask;

   // Comparator state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         res <= 2'h0;
         res_q <= 2'h0;
         res_valid <= 1'b0;
         evt <= 2'h0;
         irq <= 1'b0;
      end else begin
         res <= next_res;
         res_q <= next_res;
         res_valid <= 1'b1;
         evt <= next_evt;
         irq <= next_irq;
      end
   end

   // Registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmp_ctrl <= `DCR_RST_CMP;
         ref_ctrl <= `DCR_RST_REF;
         irq_mask <= `DCR_RST_MASK;
      end else begin
         cmp_ctrl <= next_cmp;
         ref_ctrl <= next_ref;
         irq_mask <= next_mask;
      end
   end

   // Write channel
   wire dcr_wstate_t next_wstate = (wstate == DCR_W_IDLE) ? DCR_W_BUSY :
                                   (wstate == DCR_W_BUSY) ? (do_write ? DCR_W_RESP : DCR_W_BUSY) :
                                   ((s_axi_bvalid & s_axi_bready) ? DCR_W_BUSY : DCR_W_RESP);
   wire next_awready = (next_wstate == DCR_W_BUSY) & ~(aw_got & ~do_write) & ~aw_hs;
   wire next_wready = (next_wstate == DCR_W_BUSY) & ~(w_got & ~do_write) & ~w_hs;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wstate <= DCR_W_IDLE;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `DCR_RESP_OKAY;
         aw_got <= 1'b0;
         w_got <= 1'b0;
         waddr <= 8'h00;
         wdata <= 32'h00000000;
         wstrb <= 4'h0;
      end else begin
         wstate <= next_wstate;
         aw_got <= have_aw & ~do_write;
         w_got <= have_w & ~do_write;
         waddr <= next_waddr;
         wdata <= eff_wdata;
         wstrb <= eff_wstrb;
         s_axi_awready <= (wstate == DCR_W_IDLE) ? 1'b1 :
                          (next_wstate == DCR_W_BUSY) & ~have_aw | (do_write & 1'b0) |
                          ((wstate == DCR_W_RESP) & (next_wstate == DCR_W_BUSY));
         s_axi_wready <= (wstate == DCR_W_IDLE) ? 1'b1 :
                         (next_wstate == DCR_W_BUSY) & ~have_w |
                         ((wstate == DCR_W_RESP) & (next_wstate == DCR_W_BUSY));
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `DCR_RESP_OKAY : `DCR_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   wire unused_ready = next_awready | next_wready;

   // Read channel: one outstanding read, arready low while data is held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `DCR_RESP_OKAY;
      end else begin
         if (ar_hs) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= rd_ok ? `DCR_RESP_OKAY : `DCR_RESP_SLVERR;
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
         end
      end
   end

   // Analog steering and pads
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmp_a_run <= 1'b0;
         cmp_b_run <= 1'b0;
         cmp_a_pos_from_pin <= 1'b0;
         cmp_a_neg_from_plus_pin <= 1'b0;
         cmp_b_pos_from_pin <= 1'b0;
         cmp_b_neg_from_plus_pin <= 1'b0;
         cmp_pad_out <= 2'h0;
         cmp_pad_oe_n <= 2'h3;
      end else begin
         cmp_a_run <= next_cmp[`DCR_B_A_EN];
         cmp_b_run <= next_cmp[`DCR_B_B_EN];
         cmp_a_pos_from_pin <= next_cmp[`DCR_B_A_POS];
         cmp_a_neg_from_plus_pin <= next_cmp[`DCR_B_A_NEG];
         cmp_b_pos_from_pin <= next_cmp[`DCR_B_B_POS];
         cmp_b_neg_from_plus_pin <= next_cmp[`DCR_B_B_NEG];
         cmp_pad_out <= next_res;
         cmp_pad_oe_n <= ~(pad_en & en);
      end
   end

   // Reference ladder controls; level = code/24 or 1/4 + code/32 of the source
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ref_power_on <= 1'b0;
         ref_pin_drive <= 1'b0;
         ref_range_select <= 1'b0;
         ref_source_select <= 1'b0;
         ref_level_code <= 4'h0;
      end else begin
         ref_power_on <= next_ref[`DCR_B_REF_PWR];
         ref_pin_drive <= next_ref[`DCR_B_REF_PIN];
         ref_range_select <= next_ref[`DCR_B_REF_RANGE];
         ref_source_select <= next_ref[`DCR_B_REF_SRC];
         ref_level_code <= next_ref[3:0];
      end
   end
endmodule // dcr_top
`default_nettype wire

// >>> test/dcr_top_monitor.sv
`include "dcr_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module dcr_monitor
   import dcr_pkg::*;
(
   // Clock and reset
   input wire logic aclk, aresetn,
   // Register bus
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
   // Comparators and reference
   input wire logic [1:0] cmp_raw_gt, cmp_pad_out, cmp_pad_oe_n,
   input wire logic cmp_a_run, cmp_a_pos_from_pin, cmp_a_neg_from_plus_pin,
   input wire logic cmp_b_run, cmp_b_pos_from_pin, cmp_b_neg_from_plus_pin,
   input wire logic ref_power_on, ref_pin_drive, ref_range_select, ref_source_select,
   input wire logic [3:0] ref_level_code
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [15:0] wlast;
   wire logic wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   wire logic [5:0] steer = {cmp_b_run, cmp_a_run, cmp_b_neg_from_plus_pin,
      cmp_b_pos_from_pin, cmp_a_neg_from_plus_pin, cmp_a_pos_from_pin};
   wire logic [7:0] refs = {ref_power_on, ref_pin_drive, ref_range_select,
      ref_source_select, ref_level_code};
   // Last data word taken, for the register copy checks
   always_ff @(posedge aclk) begin
      if (s_axi_wvalid && s_axi_wready) begin
         wlast <= s_axi_wdata[15:0];
      end
   end
   AST_B_LATENCY: assert property (wr_go |=> s_axi_bvalid)
      else $error("Write response late");
   AST_R_LATENCY: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("Read data late");
   AST_REF_COPY: assert property (wr_go && s_axi_awaddr == `DCR_OFS_REF_CTRL && s_axi_wstrb[0] |-> ##2 refs == wlast[7:0])
      else $error("Reference outputs differ from written value");
   AST_STEER: assert property (wr_go && s_axi_awaddr == `DCR_OFS_CMP_CTRL && s_axi_wstrb[1:0] == 2'h3 |-> ##2 steer == {wlast[11:10], wlast[3:0]})
      else $error("Comparator steering differs from written value");
   AST_OE_RUN: assert property ((~cmp_pad_oe_n & ~(steer[5:4] | $past(steer[5:4]))) == 2'h0)
      else $error("Pad driven by a disabled comparator");
   AST_PAD_OFF: assert property ((!cmp_a_run) [*3] |-> !cmp_pad_out[0])
      else $error("Disabled comparator shows a result");
   AST_RAW_A: assert property (cmp_a_run && $changed(cmp_raw_gt[0]) |-> ##[2:6] $changed(cmp_pad_out[0]))
      else $error("Comparator A result did not follow input");
   AST_RAW_B: assert property (cmp_b_run && $changed(cmp_raw_gt[1]) |-> ##[2:6] $changed(cmp_pad_out[1]))
      else $error("Comparator B result did not follow input");
endmodule // dcr_monitor
bind dcr_top dcr_monitor i_monitor (.*);
`default_nettype wire

// >>> test/tb_dual_comparator_ref_control.sv
`include "dcr_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) \
   begin \
      comparisons++; \
      if ((got) !== (exp)) begin \
         num_errors++; \
         $display("FAIL at %0t: got %h expected %h", $time, got, exp); \
      end \
   end
module tb_dual_comparator_ref_control
   import dcr_pkg::*;
;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, device_idle = 1'b0;
   logic [1:0] cmp_raw_gt = 2'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic [1:0] s_axi_bresp, s_axi_rresp, cmp_pad_out, cmp_pad_oe_n;
   logic [31:0] s_axi_rdata;
   logic cmp_a_run, cmp_a_pos_from_pin, cmp_a_neg_from_plus_pin;
   logic cmp_b_run, cmp_b_pos_from_pin, cmp_b_neg_from_plus_pin;
   logic ref_power_on, ref_pin_drive, ref_range_select, ref_source_select;
   logic [3:0] ref_level_code;
   logic [33:0] exp_q[$];
   logic [33:0] note;
   logic [31:0] d;
   int num_errors = 0;
   int comparisons = 0;
   int seed = 67870;
   wire logic [7:0] refs = {ref_power_on, ref_pin_drive, ref_range_select,
      ref_source_select, ref_level_code};
   wire logic [5:0] steer = {cmp_b_run, cmp_a_run, cmp_b_neg_from_plus_pin,
      cmp_b_pos_from_pin, cmp_a_neg_from_plus_pin, cmp_a_pos_from_pin};
   dcr_top i_dut (.*);
   always #25 aclk = ~aclk;
   task automatic end_of_test();
      if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
      input logic [1:0] r);
      exp_q.push_back({r, 32'h0});
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
      exp_q.push_back({r, v});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask
   // Scoreboard: each bus answer is matched against the oldest note
   always @(posedge aclk) begin
      if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
         note = exp_q.pop_front();
         if (s_axi_bvalid) begin
            `CHK(s_axi_bresp, note[33:32])
         end else begin
            `CHK({s_axi_rresp, s_axi_rdata}, note)
         end
      end
   end
   initial begin
      cyc(3000);
      num_errors++;
      end_of_test();
   end
   initial begin
      cyc(16);
      aresetn <= 1'b1;
      cyc(2);
      `CHK(cmp_pad_oe_n, 2'b11)
      for (int i = 0; i < 4; i++) begin
         rd(8'(i * 4), 32'h0, `DCR_RESP_OKAY);
      end
      for (int i = 0; i < 4; i++) begin
         d = $random(seed);
         wr(`DCR_OFS_REF_CTRL, d, 4'hf, `DCR_RESP_OKAY);
         wr(`DCR_OFS_REF_CTRL, ~d, 4'he, `DCR_RESP_OKAY);
         `CHK(refs, d[7:0])
         rd(`DCR_OFS_REF_CTRL, {24'h0, d[7:0]}, `DCR_RESP_OKAY);
      end
      // Give the reference ladder time to settle before comparators use it
      cyc(4);
      for (int i = 0; i < 4; i++) begin
         d = $random(seed) & 32'h8f0f;
         wr(`DCR_OFS_CMP_CTRL, d, 4'h3, `DCR_RESP_OKAY);
         cyc(2);
         `CHK(steer, {d[11:10], d[3:0]})
         `CHK(cmp_pad_oe_n, ~(d[9:8] & d[11:10]))
         rd(`DCR_OFS_CMP_CTRL, d, `DCR_RESP_OKAY);
      end
      // Enabling with inversion flips B and raises its event
      wr(`DCR_OFS_IRQ_MASK, 32'h3, 4'hf, `DCR_RESP_OKAY);
      wr(`DCR_OFS_CMP_CTRL, 32'h0c20, 4'h3, `DCR_RESP_OKAY);
      cyc(8);
      `CHK(cmp_pad_out, 2'b10)
      `CHK(irq, 1'b1)
      rd(`DCR_OFS_IRQ_STAT, 32'h2, `DCR_RESP_OKAY);
      cyc(3);
      `CHK(irq, 1'b0)
      rd(`DCR_OFS_IRQ_STAT, 32'h0, `DCR_RESP_OKAY);
      cmp_raw_gt <= 2'b01;
      cyc(8);
      `CHK(cmp_pad_out, 2'b11)
      `CHK(irq, 1'b1)
      rd(`DCR_OFS_CMP_CTRL, 32'h1ce0, `DCR_RESP_OKAY);
      cyc(3);
      `CHK(irq, 1'b0)
      // Masked event still sets its flag
      wr(`DCR_OFS_IRQ_MASK, 32'h1, 4'hf, `DCR_RESP_OKAY);
      cmp_raw_gt <= 2'b11;
      cyc(8);
      `CHK(cmp_pad_out, 2'b01)
      `CHK(irq, 1'b0)
      rd(`DCR_OFS_IRQ_STAT, 32'h2, `DCR_RESP_OKAY);
      // Idle with stop bit holds the interrupt back
      wr(`DCR_OFS_IRQ_MASK, 32'h3, 4'hf, `DCR_RESP_OKAY);
      wr(`DCR_OFS_CMP_CTRL, 32'h8c20, 4'h3, `DCR_RESP_OKAY);
      device_idle <= 1'b1;
      cmp_raw_gt <= 2'b10;
      cyc(8);
      `CHK(irq, 1'b0)
      device_idle <= 1'b0;
      cyc(3);
      `CHK(irq, 1'b1)
      wr(`DCR_OFS_CMP_CTRL, 32'h1c20, 4'h3, `DCR_RESP_OKAY);
      cyc(3);
      `CHK(irq, 1'b0)
      rd(`DCR_OFS_IRQ_STAT, 32'h0, `DCR_RESP_OKAY);
      wr(`DCR_OFS_CMP_CTRL, 32'h0, 4'h3, `DCR_RESP_OKAY);
      cyc(3);
      `CHK({cmp_pad_oe_n, cmp_pad_out}, 4'hc)
      wr(8'h14, 32'hffffffff, 4'hf, `DCR_RESP_SLVERR);
      rd(8'h14, 32'h0, `DCR_RESP_SLVERR);
      rd(`DCR_OFS_CMP_CTRL, 32'h0, `DCR_RESP_OKAY);
      `CHK(exp_q.size(), 0)
      end_of_test();
   end
endmodule // tb_dual_comparator_ref_control
`default_nettype wire
